/* common/pcsi_pkg.sv */
package pcsi_pkg;

   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] PCSI_OFS_PC_LOW      = 8'h00;
   localparam logic [7:0] PCSI_OFS_UPPER_LATCH = 8'h04;
   localparam logic [7:0] PCSI_OFS_INDIRECT    = 8'h08;
   localparam logic [7:0] PCSI_OFS_POINTER     = 8'h0C;
   localparam logic [7:0] PCSI_OFS_BANK        = 8'h10;
   localparam logic [7:0] PCSI_OFS_PC_FULL     = 8'h14;

   // Widths and depths.
   localparam int PCSI_PC_W      = 13;
   localparam int PCSI_TARGET_W  = 11;
   localparam int PCSI_STACK_D   = 8;
   localparam int PCSI_SP_W      = 3;
   localparam int PCSI_DADDR_W   = 9;

   // Field positions.
   localparam int PCSI_LATCH_PAGE_HI = 4;
   localparam int PCSI_LATCH_PAGE_LO = 3;
   localparam int PCSI_BANK_BIT      = 7;

   // Reset values.
   localparam logic [12:0] PCSI_PC_RST     = 13'h0000;
   localparam logic [7:0]  PCSI_LATCH_RST  = 8'h00;
   localparam logic [7:0]  PCSI_PTR_RST    = 8'h00;
   localparam logic [2:0]  PCSI_SP_RST     = 3'h0;
   localparam logic [12:0] PCSI_VECTOR_DEF = 13'h0004;

   // Program-flow commands from the decode logic.
   typedef enum logic [6:0] {
      PCSI_CMD_NONE   = 7'h01,
      PCSI_CMD_STEP   = 7'h02,
      PCSI_CMD_JUMP   = 7'h04,
      PCSI_CMD_CALL   = 7'h08,
      PCSI_CMD_INTR   = 7'h10,
      PCSI_CMD_RETURN = 7'h20,
      PCSI_CMD_HOLD   = 7'h40
   } pcsi_cmd_e;

   localparam logic [1:0] PCSI_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PCSI_RESP_SLVERR = 2'h2;

endpackage

/* rtl/pcsi_core.sv */
`timescale 1ns/1ps
// How it works
// - Program counter is thirteen bits; its low byte is readable and writable.
// - Upper five counter bits cannot be read; software changes them only through the latch.
// - Any reset clears the upper counter bits to zero.
// - Writing the low byte loads upper bits from latch bits four to zero.
// - Call and goto take eleven instruction bits plus latch bits four and three.
// - Program space is 8K words, split into 2K pages per branch.
// - Return stack holds eight 13-bit entries, outside program and data space.
// - The stack pointer can be neither read nor written by software.
// - Call or interrupt vectoring pushes the full program counter.
// - Return, return with literal and return from interrupt pop the stack.
// - Push and pop leave the upper-address latch unchanged.
// - Stack is a ring; the ninth push overwrites the first entry.
// - No flag reports stack overflow or underflow.
// - Latch bits seven to five have no effect on addressing.
// - The indirect port accesses the register chosen by the pointer.
// - Indirect read with pointer zero and bank bit clear returns zero.
// - Indirect write with pointer zero and bank bit clear stores nothing.
// - Indirect address is bank bit joined with the eight-bit pointer.
module pcsi_core
   import pcsi_pkg::*;
#(
   parameter logic [12:0] VECTOR_ADDR = PCSI_VECTOR_DEF
)(
   // Clock and reset.
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write address channel.
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Program-flow command from the decode logic.
   input  wire logic [6:0]                 flow_cmd,
   input  wire logic [PCSI_TARGET_W-1:0]   flow_target,
   // Program fetch address.
   output logic [PCSI_PC_W-1:0]            fetch_addr,
   // Indirect data access toward the register file.
   output logic [PCSI_DADDR_W-1:0]         ind_addr,
   output logic                            ind_rd,
   output logic                            ind_wr,
   output logic [7:0]                      ind_wdata,
   input  wire logic [7:0]                 ind_rdata
);

   logic [PCSI_PC_W-1:0]  pc_r;
   logic [7:0]            latch_r;
   logic [7:0]            ptr_r;
   logic                  bank_r;
   logic [PCSI_SP_W-1:0]  sp_r;
   logic [PCSI_PC_W-1:0]  stack_r [PCSI_STACK_D];

   logic                  aw_got_r;
   logic                  w_got_r;
   logic [7:0]            aw_addr_r;
   logic [31:0]           w_data_r;
   logic [3:0]            w_strb_r;
   logic                  ar_busy_r;
   logic [7:0]            ar_addr_r;

   logic                  wr_fire;
   logic                  wr_low;
   logic                  wr_ind;
   logic                  ind_read_now;
   logic                  ind_null;
   logic [PCSI_SP_W-1:0]  sp_dec;
   logic [31:0]           rd_word;

   function automatic logic [7:0] pcsi_merge(input logic [7:0] old_v, input logic [31:0] d,
                                            input logic [3:0] s);
      pcsi_merge = s[0] ? d[7:0] : old_v;
   endfunction

   // Byte address inside the aligned word set.
   function automatic logic pcsi_hit(input logic [7:0] a, input logic [7:0] ofs);
      pcsi_hit = (a[7:2] == ofs[7:2]);
   endfunction

   assign wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid;
   assign wr_low   = wr_fire && pcsi_hit(aw_addr_r, PCSI_OFS_PC_LOW) && w_strb_r[0];
   assign wr_ind   = wr_fire && pcsi_hit(aw_addr_r, PCSI_OFS_INDIRECT) && w_strb_r[0];
   assign ind_null = (ptr_r == PCSI_PTR_RST) && !bank_r;
   assign sp_dec   = sp_r - 3'h1;
   assign ind_read_now = ar_busy_r && !s_axi_rvalid && pcsi_hit(ar_addr_r, PCSI_OFS_INDIRECT);

   // Write address and data are taken in either order and held until the response.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_got_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_got_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // Write response; unmapped offsets answer with a slave error.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= PCSI_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         if (pcsi_hit(aw_addr_r, PCSI_OFS_PC_LOW) || pcsi_hit(aw_addr_r, PCSI_OFS_UPPER_LATCH)
             || pcsi_hit(aw_addr_r, PCSI_OFS_INDIRECT) || pcsi_hit(aw_addr_r, PCSI_OFS_POINTER)
             || pcsi_hit(aw_addr_r, PCSI_OFS_BANK))
            s_axi_bresp <= PCSI_RESP_OKAY;
         else
            s_axi_bresp <= PCSI_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Software registers; the stack and its pointer have no address.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         latch_r <= PCSI_LATCH_RST;
         ptr_r   <= PCSI_PTR_RST;
         bank_r  <= 1'b0;
      end
      else if (wr_fire)
      begin
         if (pcsi_hit(aw_addr_r, PCSI_OFS_UPPER_LATCH))
            latch_r <= pcsi_merge(latch_r, w_data_r, w_strb_r);
         if (pcsi_hit(aw_addr_r, PCSI_OFS_POINTER))
            ptr_r <= pcsi_merge(ptr_r, w_data_r, w_strb_r);
         if (pcsi_hit(aw_addr_r, PCSI_OFS_BANK) && w_strb_r[0])
            bank_r <= w_data_r[PCSI_BANK_BIT];
      end
   end

   // Program counter; a software write to the low byte wins over the flow command.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pc_r <= PCSI_PC_RST;
      else if (wr_low)
         pc_r <= {latch_r[PCSI_LATCH_PAGE_HI:0], w_data_r[7:0]};
      else
      begin
         case (flow_cmd)
            PCSI_CMD_STEP:   pc_r <= pc_r + 13'h0001;
            PCSI_CMD_JUMP,
            PCSI_CMD_CALL:   pc_r <= {latch_r[PCSI_LATCH_PAGE_HI:PCSI_LATCH_PAGE_LO],
                                      flow_target};
            PCSI_CMD_INTR:   pc_r <= VECTOR_ADDR;
            PCSI_CMD_RETURN: pc_r <= stack_r[sp_dec];
            default:         pc_r <= pc_r;
         endcase
      end
   end

   // Return stack ring; the pointer wraps both ways and raises no flag.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sp_r <= PCSI_SP_RST;
      else if (!wr_low)
      begin
         case (flow_cmd)
            PCSI_CMD_CALL,
            PCSI_CMD_INTR:   sp_r <= sp_r + 3'h1;
            PCSI_CMD_RETURN: sp_r <= sp_dec;
            default:         sp_r <= sp_r;
         endcase
      end
   end

   // Call pushes the address of the next instruction; interrupt the current one.
   always_ff @(posedge aclk)
   begin
      if (!wr_low)
      begin
         if (flow_cmd == PCSI_CMD_CALL)
            stack_r[sp_r] <= pc_r + 13'h0001;
         else if (flow_cmd == PCSI_CMD_INTR)
            stack_r[sp_r] <= pc_r;
      end
   end

   // Register read path; upper counter bits are kept out of every readable word.
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (pcsi_hit(ar_addr_r, PCSI_OFS_PC_LOW))
         rd_word = {24'h000000, pc_r[7:0]};
      else if (pcsi_hit(ar_addr_r, PCSI_OFS_UPPER_LATCH))
         rd_word = {24'h000000, latch_r};
      else if (pcsi_hit(ar_addr_r, PCSI_OFS_INDIRECT))
         rd_word = ind_null ? 32'h0000_0000 : {24'h000000, ind_rdata};
      else if (pcsi_hit(ar_addr_r, PCSI_OFS_POINTER))
         rd_word = {24'h000000, ptr_r};
      else if (pcsi_hit(ar_addr_r, PCSI_OFS_BANK))
         rd_word = {24'h000000, bank_r, 7'h00};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ar_busy_r     <= 1'b0;
         ar_addr_r     <= 8'h00;
         s_axi_arready <= 1'b0;
      end
      else
      begin
         s_axi_arready <= !ar_busy_r && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            ar_busy_r <= 1'b1;
            ar_addr_r <= s_axi_araddr;
         end
         else if (s_axi_rvalid && s_axi_rready)
            ar_busy_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= PCSI_RESP_OKAY;
      end
      else if (ar_busy_r && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         if (pcsi_hit(ar_addr_r, PCSI_OFS_PC_LOW) || pcsi_hit(ar_addr_r, PCSI_OFS_UPPER_LATCH)
             || pcsi_hit(ar_addr_r, PCSI_OFS_INDIRECT) || pcsi_hit(ar_addr_r, PCSI_OFS_POINTER)
             || pcsi_hit(ar_addr_r, PCSI_OFS_BANK))
            s_axi_rresp <= PCSI_RESP_OKAY;
         else
            s_axi_rresp <= PCSI_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Registered outputs toward fetch and the register file.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fetch_addr <= PCSI_PC_RST;
         ind_addr   <= 9'h000;
         ind_rd     <= 1'b0;
         ind_wr     <= 1'b0;
         ind_wdata  <= 8'h00;
      end
      else
      begin
         fetch_addr <= pc_r;
         ind_addr   <= {bank_r, ptr_r};
         ind_rd     <= ind_read_now && !ind_null;
         ind_wr     <= wr_ind && !ind_null;
         ind_wdata  <= w_data_r[7:0];
      end
   end

endmodule

/* verif/pcsi_regfile_model.sv */
`timescale 1ns/1ps
// Register file behind the indirect port; it answers at once from its array.
module pcsi_regfile_model (
   // Clock.
   input  wire logic       aclk,
   // Indirect access.
   input  wire logic [8:0] ind_addr,
   input  wire logic       ind_wr,
   input  wire logic [7:0] ind_wdata,
   output logic [7:0]      ind_rdata
);
   logic [7:0] mem [512];
   initial
   begin
      for (int i = 0; i < 512; i++)
         mem[i] = 8'(i) ^ 8'hA5;
   end
   assign ind_rdata = mem[ind_addr];
   always @(posedge aclk)
   begin
      if (ind_wr === 1'b1)
         mem[ind_addr] <= ind_wdata;
   end
endmodule

/* verif/pcsi_chk.sv */
`timescale 1ns/1ps
module pcsi_chk
   import pcsi_pkg::*;
#(
   parameter logic [12:0] VECTOR_ADDR = PCSI_VECTOR_DEF
)(
   // Clock and reset.
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Program flow and indirect access.
   input wire logic [6:0]  flow_cmd,
   input wire logic [10:0] flow_target,
   input wire logic [12:0] fetch_addr,
   input wire logic [8:0]  ind_addr,
   input wire logic        ind_rd,
   input wire logic        ind_wr
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_call_ret;
      flow_cmd == PCSI_CMD_CALL ##1 flow_cmd == PCSI_CMD_RETURN;
   endsequence
   sequence s_intr_ret;
      flow_cmd == PCSI_CMD_INTR ##1 flow_cmd == PCSI_CMD_RETURN;
   endsequence
   a_step_inc: assert property (flow_cmd == PCSI_CMD_STEP |->
      ##2 fetch_addr == $past(fetch_addr) + 13'h1) else $error("step did not add one");
   a_goto_low: assert property (flow_cmd == PCSI_CMD_JUMP |->
      ##2 fetch_addr[10:0] == $past(flow_target, 2)) else $error("goto target lost");
   a_call_ret: assert property (s_call_ret |->
      ##2 fetch_addr == $past(fetch_addr, 2) + 13'h1) else $error("call return mismatch");
   a_intr_vec: assert property (flow_cmd == PCSI_CMD_INTR |->
      ##2 fetch_addr == VECTOR_ADDR) else $error("interrupt vector wrong");
   a_intr_ret: assert property (s_intr_ret |->
      ##2 fetch_addr == $past(fetch_addr, 2)) else $error("interrupt return mismatch");
   a_ind_nonzero: assert property ((ind_rd || ind_wr) |-> ind_addr != 9'h000)
      else $error("indirect access at address zero");
   a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   a_reset_clear: assert property (disable iff (1'b0) $rose(aresetn) |->
      fetch_addr == 13'h0000 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset not clear");
endmodule
bind pcsi_core pcsi_chk #(.VECTOR_ADDR(VECTOR_ADDR)) i_chk (
   .aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .flow_cmd(flow_cmd), .flow_target(flow_target), .fetch_addr(fetch_addr),
   .ind_addr(ind_addr), .ind_rd(ind_rd), .ind_wr(ind_wr)
);

/* verif/tb_program_counter_stack_indirect.sv */
`timescale 1ns/1ps
module tb_program_counter_stack_indirect;
   import pcsi_pkg::*;
   logic        aclk = 0;
   logic        aresetn = 0;
   logic [7:0]  s_axi_awaddr = 0;
   logic [7:0]  s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [6:0]  flow_cmd = PCSI_CMD_HOLD;
   logic [10:0] flow_target = 0;
   wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [12:0] fetch_addr;
   wire logic [8:0]  ind_addr;
   wire logic        ind_rd, ind_wr;
   wire logic [7:0]  ind_wdata, ind_rdata;
   int          err_total = 0, checks_done = 0, wr_cnt = 0, n0;
   int          seed = 32'h07A4;
   logic [12:0] pc, p0, stk [9];
   logic [10:0] t;
   logic [7:0]  p, d;
   logic        b;
   logic        slow = 0;
   pcsi_core i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .flow_cmd(flow_cmd), .flow_target(flow_target), .fetch_addr(fetch_addr),
      .ind_addr(ind_addr), .ind_rd(ind_rd), .ind_wr(ind_wr),
      .ind_wdata(ind_wdata), .ind_rdata(ind_rdata)
   );
   pcsi_regfile_model i_rf (.aclk(aclk), .ind_addr(ind_addr), .ind_wr(ind_wr),
      .ind_wdata(ind_wdata), .ind_rdata(ind_rdata));
   always #12.5 aclk = ~aclk;
   always @(posedge aclk)
      if (ind_wr === 1'b1)
         wr_cnt++;
   task end_sim;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tmo(input int n);
      if (n >= 50)
      begin
         err_total++;
         $display("ERROR %0t: bus wait ran out", $time);
         end_sim();
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= !slow;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
         if (s_axi_bvalid && s_axi_bready)
            break;
         if (n == 3)
            s_axi_bready <= 1;
      end
      tmo(n);
      s_axi_bready <= 0;
      chk(s_axi_bresp, er);
      @(posedge aclk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= !slow;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 0;
         if (s_axi_rvalid && s_axi_rready)
            break;
         if (n == 3)
            s_axi_rready <= 1;
      end
      tmo(n);
      s_axi_rready <= 0;
      chk(s_axi_rdata, v);
      chk(s_axi_rresp, er);
      @(posedge aclk);
   endtask
   task issue(input logic [6:0] c, input logic [10:0] tg);
      @(posedge aclk);
      flow_cmd <= c;
      flow_target <= tg;
   endtask
   task settle;
      @(posedge aclk);
      flow_cmd <= PCSI_CMD_HOLD;
      @(posedge aclk);
      #1 pc = fetch_addr;
   endtask
   task flow(input logic [6:0] c, input logic [10:0] tg);
      issue(c, tg);
      settle();
   endtask
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(PCSI_OFS_PC_LOW, 0, PCSI_RESP_OKAY);
      rd(PCSI_OFS_UPPER_LATCH, 0, PCSI_RESP_OKAY);
      rd(PCSI_OFS_PC_FULL, 0, PCSI_RESP_SLVERR);
      wr(PCSI_OFS_PC_FULL, 32'h5A, PCSI_RESP_SLVERR);
      wr(PCSI_OFS_UPPER_LATCH, 32'h1F, PCSI_RESP_OKAY);
      wr(PCSI_OFS_PC_LOW, 32'hFF, PCSI_RESP_OKAY);
      settle();
      chk(pc, 13'h1FFF);
      rd(PCSI_OFS_PC_LOW, 32'hFF, PCSI_RESP_OKAY);
      flow(PCSI_CMD_STEP, 0);
      chk(pc, 13'h0000);
      wr(PCSI_OFS_UPPER_LATCH, 32'h08, PCSI_RESP_OKAY);
      for (int i = 0; i < 9; i++)
      begin
         t = 11'($random(seed));
         stk[i] = pc + 13'h1;
         flow(PCSI_CMD_CALL, t);
         chk(pc, {2'b01, t});
      end
      rd(PCSI_OFS_UPPER_LATCH, 32'h08, PCSI_RESP_OKAY);
      for (int i = 0; i < 9; i++)
      begin
         flow(PCSI_CMD_RETURN, 0);
         chk(pc, stk[i == 8 ? 8 : 8 - i]);
      end
      p0 = pc;
      flow(PCSI_CMD_INTR, 0);
      chk(pc, PCSI_VECTOR_DEF);
      issue(PCSI_CMD_CALL, 11'h123);
      issue(PCSI_CMD_RETURN, 0);
      settle();
      chk(pc, PCSI_VECTOR_DEF + 13'h1);
      flow(PCSI_CMD_RETURN, 0);
      chk(pc, p0);
      issue(PCSI_CMD_INTR, 0);
      issue(PCSI_CMD_RETURN, 0);
      settle();
      chk(pc, p0);
      flow(PCSI_CMD_JUMP, 11'h7FF);
      chk(pc, 13'h0FFF);
      for (int i = 0; i < 4; i++)
      begin
         slow = i[0];
         p = 8'($random(seed)) | 8'h01;
         d = 8'($random(seed));
         b = 1'($random(seed));
         wr(PCSI_OFS_BANK, {24'h0, b, 7'h00}, PCSI_RESP_OKAY);
         wr(PCSI_OFS_POINTER, {24'h0, p}, PCSI_RESP_OKAY);
         wr(PCSI_OFS_INDIRECT, {24'h0, d}, PCSI_RESP_OKAY);
         chk(ind_addr, {b, p});
         rd(PCSI_OFS_INDIRECT, {24'h0, d}, PCSI_RESP_OKAY);
      end
      slow = 0;
      wr(PCSI_OFS_BANK, 0, PCSI_RESP_OKAY);
      wr(PCSI_OFS_POINTER, 0, PCSI_RESP_OKAY);
      n0 = wr_cnt;
      wr(PCSI_OFS_INDIRECT, 32'h55, PCSI_RESP_OKAY);
      chk(wr_cnt, n0);
      rd(PCSI_OFS_INDIRECT, 0, PCSI_RESP_OKAY);
      wr(PCSI_OFS_UPPER_LATCH, 32'h01, PCSI_RESP_OKAY);
      wr(PCSI_OFS_PC_LOW, 32'hFF, PCSI_RESP_OKAY);
      flow(PCSI_CMD_STEP, 0);
      chk(pc, 13'h0200);
      @(posedge aclk);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      settle();
      chk(pc, PCSI_PC_RST);
      end_sim();
   end
endmodule
